/* File: design/qrel_pkg.sv */
// package: register offsets, field layout and image constants for the queued write bus-release block
package qrel_pkg;

   // ************************************************************
   // apb register map (byte offsets)
   // ************************************************************
   localparam logic [7:0] OFF_ERROR_REPORT  = 8'h00;
   localparam logic [7:0] OFF_INT_REASON    = 8'h04;
   localparam logic [7:0] OFF_LBA_LOW       = 8'h08;
   localparam logic [7:0] OFF_LBA_MID       = 8'h0C;
   localparam logic [7:0] OFF_LBA_HIGH      = 8'h10;
   localparam logic [7:0] OFF_DRIVE_SEL     = 8'h14;
   localparam logic [7:0] OFF_STATUS        = 8'h18;
   localparam logic [7:0] OFF_DEV_CONTROL   = 8'h1C;
   localparam logic [7:0] OFF_CMD_CTRL      = 8'h20;
   localparam logic [7:0] OFF_BLOCK_STATE   = 8'h24;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int TAG_MSB           = 7;
   localparam int TAG_LSB           = 3;
   localparam int REL_BIT           = 2;
   localparam int IO_BIT            = 1;
   localparam int CD_BIT            = 0;
   localparam int DRIVE_SEL_BIT     = 4;
   localparam int HOB_BIT           = 7;
   localparam int BUSY_BIT          = 7;
   localparam int READY_BIT         = 6;
   localparam int FAULT_BIT         = 5;
   localparam int SERVICE_PENDING_FLAG_BIT          = 4;
   localparam int DRQ_BIT           = 3;
   localparam int ERR_BIT           = 0;

   // cmd_ctrl write bits (pulses in bits 2:0; stored queue enable; tag and image fields)
   localparam int CTL_RELEASE_BIT   = 0;
   localparam int CTL_SELF_READY    = 1;
   localparam int CTL_SERVICE_BIT   = 2;
   localparam int CTL_QUEUE_EN_BIT  = 8;
   localparam int CTL_TAG_LSB       = 16;
   localparam int CTL_IMAGE_LSB     = 24;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] RST_STATUS    = 8'h80;
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;

   // image chosen by firmware for the service answer
   typedef enum logic [1:0] {
      SVC_DATA,
      SVC_DONE,
      SVC_ERROR
   } svc_image_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RELEASED,
      ST_SERVICE_PENDING_FLAG_WAIT,
      ST_SERVICED
   } rel_state_t;

   // apb request carrier
   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } apb_req_t;

   typedef struct packed {
      logic        ready;
      logic        slverr;
      logic [31:0] rdata;
   } apb_rsp_t;

endpackage

/* File: design/queued_write_bus_release_service.sv */
// module: task-file register image for bus release and service request of a queued write
`timescale 1ns/1ps
// ************************************************************
// Notes on behaviour
// [R01] release image applied when bus freed early
// [R02] tag of released command in tag field
// [R03] tag zero without queuing or overlap
// [R04] release flag set on release
// [R05] direction flag cleared on release
// [R06] command-or-data flag cleared: data transfer
// [R07] drive select keeps selected device
// [R08] busy cleared on release
// [R09] ready set on release
// [R10] fault cleared on release
// [R11] data request cleared on release
// [R12] error cleared on release
// [R13] service pending zero unless another ready
// [R14] service pending set when another ready
// [R15] service pending set when released command ready
// [R16] high-order select makes fields read reserved
// [R17] service request changes only service bit
// [R18] service command presents matching image
// [R19] tag occupies sector count bits 7:3
// [R20] zero direction means host to device
// [R21] host issues service before expecting data
// ************************************************************
module queued_write_bus_release_service (
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [7:0]           paddr_i,
   input  wire logic [31:0]          pwdata_i,
   output logic                      pready_o,
   output logic                      pslverr_o,
   output logic [31:0]               prdata_o,
   input  wire logic                 other_cmd_ready_i,
   output logic                      released_o,
   output logic                      service_pending_o
);

   // ************************************************************
   // bus decode
   // ************************************************************
   qrel_pkg::apb_req_t req;
   qrel_pkg::apb_rsp_t rsp;
   logic               wr_en;
   logic               rd_en;

   assign req.sel    = psel_i;
   assign req.enable = penable_i;
   assign req.write  = pwrite_i;
   assign req.addr   = paddr_i;
   assign req.wdata  = pwdata_i;

   assign wr_en = req.sel & req.enable & req.write;
   assign rd_en = req.sel & req.enable & ~req.write;

   // ************************************************************
   // register state
   // ************************************************************
   logic [7:0]             error_q;
   logic [4:0]             tag_q;
   logic                   rel_q;
   logic                   io_q;
   logic                   cd_q;
   logic [7:0]             reason_img;
   logic [7:0]             lba_low_q;
   logic [7:0]             lba_mid_q;
   logic [7:0]             lba_high_q;
   logic [7:0]             drive_q;
   logic                   busy_q;
   logic                   ready_q;
   logic                   fault_q;
   logic                   service_pending_flag_q;
   logic                   drq_q;
   logic                   err_q;
   logic [7:0]             status_img;
   logic                   hob_q;
   logic                   queue_en_q;
   logic                   self_ready_q;
   qrel_pkg::rel_state_t   state_q;
   logic [31:0]            rdata_q;

   logic                   ctl_wr;
   logic                   do_release;
   logic                   do_self_ready;
   logic                   do_service;
   logic [4:0]             wr_tag;
   logic                   wr_queue_en;
   qrel_pkg::svc_image_t   wr_image;
   logic [4:0]             rel_tag;
   logic                   service_pending_flag_set;
   logic                   svc_live;
   logic                   wr_error;
   logic                   wr_reason;
   logic                   wr_drive;
   logic                   wr_dev_ctrl;
   logic                   rd_setup;
   logic                   bad_addr;
   logic                   ro_write;

   assign ctl_wr        = wr_en && (req.addr == qrel_pkg::OFF_CMD_CTRL);
   assign do_release    = ctl_wr && req.wdata[qrel_pkg::CTL_RELEASE_BIT];
   assign do_self_ready = ctl_wr && req.wdata[qrel_pkg::CTL_SELF_READY];
   assign do_service    = ctl_wr && req.wdata[qrel_pkg::CTL_SERVICE_BIT];
   assign wr_queue_en   = req.wdata[qrel_pkg::CTL_QUEUE_EN_BIT];
   assign wr_tag        = req.wdata[qrel_pkg::CTL_TAG_LSB +: 5];
   assign wr_image      = qrel_pkg::svc_image_t'(req.wdata[qrel_pkg::CTL_IMAGE_LSB +: 2]);

   // ************************************************************
   // access decode
   // ************************************************************
   // service while idle has no command to answer, so it is dropped
   assign svc_live    = do_service && (state_q != qrel_pkg::ST_IDLE);
   assign wr_error    = wr_en && (req.addr == qrel_pkg::OFF_ERROR_REPORT);
   assign wr_reason   = wr_en && (req.addr == qrel_pkg::OFF_INT_REASON);
   assign wr_drive    = wr_en && (req.addr == qrel_pkg::OFF_DRIVE_SEL);
   assign wr_dev_ctrl = wr_en && (req.addr == qrel_pkg::OFF_DEV_CONTROL);
   assign rd_setup    = req.sel && !req.enable && !req.write;
   assign bad_addr    = (req.addr > qrel_pkg::OFF_BLOCK_STATE) || (req.addr[1:0] != 2'h0);
   assign ro_write    = req.write && (req.addr == qrel_pkg::OFF_STATUS || req.addr == qrel_pkg::OFF_BLOCK_STATE);

   // tag forced to zero when queuing or overlap is off
   assign rel_tag = wr_queue_en ? wr_tag : 5'h00;   // [R02] [R03]

   // service request: another queued command or the released one is ready
   assign service_pending_flag_set = (state_q != qrel_pkg::ST_IDLE) &&
                     (other_cmd_ready_i || self_ready_q || do_self_ready);   // [R14] [R15]

   // ************************************************************
   // command sequencing
   // ************************************************************
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= qrel_pkg::ST_IDLE;
      end else if (do_release) begin
         state_q <= qrel_pkg::ST_RELEASED;   // [R01]
      end else if (do_service && state_q != qrel_pkg::ST_IDLE) begin
         state_q <= qrel_pkg::ST_SERVICED;   // [R18]
      end else if (state_q == qrel_pkg::ST_RELEASED && service_pending_flag_set) begin
         state_q <= qrel_pkg::ST_SERVICE_PENDING_FLAG_WAIT;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         self_ready_q <= 1'b0;
      end else if (do_release || do_service) begin
         self_ready_q <= 1'b0;
      end else if (do_self_ready) begin
         self_ready_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         queue_en_q <= 1'b0;
      end else if (ctl_wr) begin
         queue_en_q <= wr_queue_en;
      end
   end

   // ************************************************************
   // sector count and address bytes
   // ************************************************************
   // tag keeps the released command's tag until software rewrites the byte
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tag_q <= qrel_pkg::RST_BYTE[qrel_pkg::TAG_MSB:qrel_pkg::TAG_LSB];
      end else if (do_release) begin
         tag_q <= rel_tag;   // [R01] [R02] [R03] [R19]
      end else if (wr_reason) begin
         tag_q <= req.wdata[qrel_pkg::TAG_MSB:qrel_pkg::TAG_LSB];
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rel_q <= qrel_pkg::RST_BYTE[qrel_pkg::REL_BIT];
      end else if (do_release) begin
         rel_q <= 1'b1;   // [R04]
      end else if (svc_live) begin
         rel_q <= 1'b0;   // [R18]
      end else if (wr_reason) begin
         rel_q <= req.wdata[qrel_pkg::REL_BIT];
      end
   end

   // a write command always moves data from the host
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         io_q <= qrel_pkg::RST_BYTE[qrel_pkg::IO_BIT];
      end else if (do_release) begin
         io_q <= 1'b0;   // [R05] [R20]
      end else if (svc_live) begin
         io_q <= (wr_image != qrel_pkg::SVC_DATA);   // [R18]
      end else if (wr_reason) begin
         io_q <= req.wdata[qrel_pkg::IO_BIT];
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cd_q <= qrel_pkg::RST_BYTE[qrel_pkg::CD_BIT];
      end else if (do_release) begin
         cd_q <= 1'b0;   // [R06]
      end else if (svc_live) begin
         cd_q <= (wr_image != qrel_pkg::SVC_DATA);   // [R18]
      end else if (wr_reason) begin
         cd_q <= req.wdata[qrel_pkg::CD_BIT];
      end
   end

   assign reason_img = {tag_q, rel_q, io_q, cd_q};   // [R19]

   // address bytes are reserved in the release image; kept as last written
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lba_low_q  <= qrel_pkg::RST_BYTE;
         lba_mid_q  <= qrel_pkg::RST_BYTE;
         lba_high_q <= qrel_pkg::RST_BYTE;
      end else if (wr_en) begin
         if (req.addr == qrel_pkg::OFF_LBA_LOW) begin
            lba_low_q <= req.wdata[7:0];
         end
         if (req.addr == qrel_pkg::OFF_LBA_MID) begin
            lba_mid_q <= req.wdata[7:0];
         end
         if (req.addr == qrel_pkg::OFF_LBA_HIGH) begin
            lba_high_q <= req.wdata[7:0];
         end
      end
   end

   // drive select is never touched by release or service
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         drive_q <= qrel_pkg::RST_BYTE;
      end else if (wr_drive) begin
         drive_q <= req.wdata[7:0];   // [R07]
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hob_q <= 1'b0;
      end else if (wr_dev_ctrl) begin
         hob_q <= req.wdata[qrel_pkg::HOB_BIT];   // [R16]
      end
   end

   // ************************************************************
   // status and error
   // ************************************************************
   // busy leaves its reset value only through release or service
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_q <= qrel_pkg::RST_STATUS[qrel_pkg::BUSY_BIT];
      end else if (do_release || svc_live) begin
         busy_q <= 1'b0;   // [R08] [R18]
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ready_q <= qrel_pkg::RST_STATUS[qrel_pkg::READY_BIT];
      end else if (do_release || svc_live) begin
         ready_q <= 1'b1;   // [R09] [R18]
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fault_q <= qrel_pkg::RST_STATUS[qrel_pkg::FAULT_BIT];
      end else if (do_release || svc_live) begin
         fault_q <= 1'b0;   // [R10] [R18]
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         drq_q <= qrel_pkg::RST_STATUS[qrel_pkg::DRQ_BIT];
      end else if (do_release) begin
         drq_q <= 1'b0;   // [R11]
      end else if (svc_live) begin
         drq_q <= (wr_image == qrel_pkg::SVC_DATA);   // [R18]
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         err_q <= qrel_pkg::RST_STATUS[qrel_pkg::ERR_BIT];
      end else if (do_release) begin
         err_q <= 1'b0;   // [R12]
      end else if (svc_live) begin
         err_q <= (wr_image == qrel_pkg::SVC_ERROR);   // [R18]
      end
   end

   // only release and service clear it; any other cycle may only set it
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         service_pending_flag_q <= qrel_pkg::RST_STATUS[qrel_pkg::SERVICE_PENDING_FLAG_BIT];
      end else if (do_release || svc_live) begin
         service_pending_flag_q <= other_cmd_ready_i;   // [R13] [R14]
      end else if (service_pending_flag_set) begin
         service_pending_flag_q <= 1'b1;   // [R14] [R15] [R17]
      end
   end

   // bits 2:1 carry nothing here and read as zero
   assign status_img = {busy_q, ready_q, fault_q, service_pending_flag_q, drq_q, 2'h0, err_q};

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         error_q <= qrel_pkg::RST_BYTE;
      end else if (do_release) begin
         error_q <= qrel_pkg::RST_BYTE;
      end else if (wr_error) begin
         // firmware loads error code before an error service
         error_q <= req.wdata[7:0];
      end
   end

   // ************************************************************
   // read path
   // ************************************************************
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= qrel_pkg::RD_UNMAPPED;
      end else if (rd_setup) begin
         // registered in setup so the access phase answers at once
         unique case (req.addr)
            qrel_pkg::OFF_ERROR_REPORT: rdata_q <= {24'h000000, error_q};
            qrel_pkg::OFF_INT_REASON:   rdata_q <= {24'h000000, hob_q ? 8'h00 : reason_img}; // [R16]
            qrel_pkg::OFF_LBA_LOW:      rdata_q <= {24'h000000, hob_q ? 8'h00 : lba_low_q};  // [R16]
            qrel_pkg::OFF_LBA_MID:      rdata_q <= {24'h000000, hob_q ? 8'h00 : lba_mid_q};  // [R16]
            qrel_pkg::OFF_LBA_HIGH:     rdata_q <= {24'h000000, hob_q ? 8'h00 : lba_high_q}; // [R16]
            qrel_pkg::OFF_DRIVE_SEL:    rdata_q <= {24'h000000, drive_q};
            qrel_pkg::OFF_STATUS:       rdata_q <= {24'h000000, status_img};
            qrel_pkg::OFF_DEV_CONTROL:  rdata_q <= {24'h000000, hob_q, 7'h00};
            qrel_pkg::OFF_CMD_CTRL:     rdata_q <= {23'h000000, queue_en_q, 8'h00};
            qrel_pkg::OFF_BLOCK_STATE:  rdata_q <= {29'h00000000, self_ready_q, state_q};
            default:                    rdata_q <= qrel_pkg::RD_UNMAPPED;
         endcase
      end
   end

   // slave answers in the first access cycle; unmapped reads and writes flag slverr
   always_comb begin
      rsp.ready  = 1'b1;
      rsp.rdata  = rdata_q;
      rsp.slverr = (wr_en || rd_en) && (bad_addr || ro_write);
   end

   assign pready_o          = rsp.ready;
   assign pslverr_o         = rsp.slverr;
   assign prdata_o          = rsp.rdata;
   assign released_o        = (state_q == qrel_pkg::ST_RELEASED) || (state_q == qrel_pkg::ST_SERVICE_PENDING_FLAG_WAIT);
   assign service_pending_o = service_pending_flag_q;

endmodule // queued_write_bus_release_service

/* File: dv/qrel_chk.sv */
// checker: release-state and service-flag assertions for the queued write bus-release block
`timescale 1ns/1ps
module qrel_chk (
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic [31:0] prdata_o,
   input wire logic        other_cmd_ready_i,
   input wire logic        released_o,
   input wire logic        service_pending_o
);
   // ********
   // helpers
   // ********
   logic cmd_wr;
   assign cmd_wr = psel_i && penable_i && pwrite_i && paddr_i == qrel_pkg::OFF_CMD_CTRL;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_release; cmd_wr && pwdata_i[0]; endsequence
   sequence s_service; released_o && cmd_wr && !pwdata_i[0] && pwdata_i[2]; endsequence
   sequence s_self; released_o && cmd_wr && pwdata_i[1:0] == 2'b10 && !pwdata_i[2]; endsequence
   // ********
   // properties
   // ********
   property p_rel; s_release |=> released_o; endproperty
   a_rel: assert property (p_rel) else $error("release not seen");
   property p_srv0; s_release |=> service_pending_o == $past(other_cmd_ready_i); endproperty
   a_srv0: assert property (p_srv0) else $error("service flag wrong at release");
   property p_other; released_o && other_cmd_ready_i && !cmd_wr |=> service_pending_o && released_o; endproperty
   a_other: assert property (p_other) else $error("other ready not flagged");
   property p_self; s_self |-> ##[1:2] service_pending_o; endproperty
   a_self: assert property (p_self) else $error("self ready not flagged");
   property p_svc; s_service |=> !released_o; endproperty
   a_svc: assert property (p_svc) else $error("service kept release");
   property p_idle; !released_o && cmd_wr && !pwdata_i[0] |=> !released_o; endproperty
   a_idle: assert property (p_idle) else $error("release without cause");
   property p_hold; released_o && !cmd_wr |=> released_o; endproperty
   a_hold: assert property (p_hold) else $error("release dropped");
   property p_sticky; service_pending_o && !cmd_wr |=> service_pending_o; endproperty
   a_sticky: assert property (p_sticky) else $error("service flag dropped");
endmodule // qrel_chk

bind queued_write_bus_release_service qrel_chk u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .prdata_o(prdata_o), .other_cmd_ready_i(other_cmd_ready_i),
   .released_o(released_o), .service_pending_o(service_pending_o));

/* File: dv/host_adapter_model.sv */
// partner: host adapter model with apb master transfers
`timescale 1ns/1ps
module host_adapter_model (
   input  wire logic               ref_clk_i,
   input  wire qrel_pkg::apb_rsp_t rsp_i,
   input  wire logic               service_pending_flag_i,
   output qrel_pkg::apb_req_t      req_o
);
   initial req_o = '0;
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v,
                       output logic [31:0] rd, output logic err);
      @(posedge ref_clk_i);
      req_o <= '{sel: 1'b1, enable: 1'b0, write: w, addr: a, wdata: v};
      @(posedge ref_clk_i);
      req_o.enable <= 1'b1;
      @(posedge ref_clk_i);
      while (!rsp_i.ready) @(posedge ref_clk_i);
      rd = rsp_i.rdata;
      err = rsp_i.slverr;
      req_o <= '0;
   endtask
   // no service command until the device asks for it
   task automatic serve(input logic [1:0] img);
      logic [31:0] r;
      logic        e;
      while (!service_pending_flag_i) @(posedge ref_clk_i);
      xfer(1'b1, 8'h20, {6'h00, img, 24'h000004}, r, e);
   endtask
endmodule // host_adapter_model

/* File: dv/queued_write_bus_release_service_tb_top.sv */
// testbench: bus-release and service scenarios for the queued write block
`timescale 1ns/1ps
module queued_write_bus_release_service_tb_top;
   logic               ref_clk_i = 1'b0;
   logic               rst_i     = 1'b1;
   logic               other_q   = 1'b0;
   logic               released;
   logic               service_pending_flag;
   qrel_pkg::apb_req_t req;
   qrel_pkg::apb_rsp_t rsp;
   int                 failures  = 0;
   int                 n_checks  = 0;
   logic [31:0]        d;
   logic               e;
   logic [4:0]         t;
   logic               io;
   always #2 ref_clk_i = ~ref_clk_i;
   host_adapter_model host (.ref_clk_i(ref_clk_i), .rsp_i(rsp), .service_pending_flag_i(service_pending_flag), .req_o(req));
   queued_write_bus_release_service dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(req.sel),
      .penable_i(req.enable), .pwrite_i(req.write), .paddr_i(req.addr), .pwdata_i(req.wdata),
      .pready_o(rsp.ready), .pslverr_o(rsp.slverr), .prdata_o(rsp.rdata), .other_cmd_ready_i(other_q),
      .released_o(released), .service_pending_o(service_pending_flag));
   // ********
   // tasks
   // ********
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_checks++;
      if (got !== ex) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      host.xfer(1'b1, a, v, d, e);
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] ex);
      host.xfer(1'b0, a, 32'h0, d, e);
      chk(nm, ex, d);
   endtask
   task automatic print_verdict;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ********
   // tests
   // ********
   initial begin
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rc("status", 8'h18, 32'h80);
      wr(8'h14, 32'h10);
      wr(8'h20, 32'h001F0101);
      rc("count", 8'h04, 32'hFC);
      rc("status", 8'h18, 32'h40);
      rc("drive", 8'h14, 32'h10);
      chk("released", 32'h1, {31'h0, released});
      wr(8'h08, 32'h5A);
      wr(8'h1C, 32'h80);
      rc("hob count", 8'h04, 32'h0);
      rc("hob lba", 8'h08, 32'h0);
      wr(8'h1C, 32'h0);
      rc("lba", 8'h08, 32'h5A);
      @(posedge ref_clk_i) other_q <= 1'b1;
      @(posedge ref_clk_i) other_q <= 1'b0;
      rc("status", 8'h18, 32'h50);
      chk("service_pending_flag pin", 32'h1, {31'h0, service_pending_flag});
      rc("count", 8'h04, 32'hFC);
      rc("unmapped", 8'h28, 32'h0);
      chk("slverr", 32'h1, {31'h0, e});
      // one pass per service image; first pass has queuing off
      for (int i = 0; i < 3; i++) begin
         t = (i != 0) ? 5'(i + 5) : 5'h00;
         io = (i != 0);
         wr(8'h20, {6'h00, i[1:0], 3'h0, 5'(i + 5), 7'h00, io, 8'h01});
         rc("count", 8'h04, {24'h0, t, 3'b100});
         rc("status", 8'h18, 32'h40);
         wr(8'h20, {6'h00, i[1:0], 24'h000002});
         host.serve(i[1:0]);
         rc("count", 8'h04, {24'h0, t, 1'b0, io, io});
         rc("status", 8'h18, {24'h0, 4'h4, i == 0, 2'b00, i == 2});
      end
      wr(8'h20, 32'h4);
      chk("released", 32'h0, {31'h0, released});
      rc("state", 8'h24, 32'h3);
      // another command already waiting when the bus is released
      @(posedge ref_clk_i) other_q <= 1'b1;
      wr(8'h20, 32'h001F0101);
      rc("status", 8'h18, 32'h50);
      chk("service_pending_flag pin", 32'h1, {31'h0, service_pending_flag});
      other_q <= 1'b0;
      print_verdict;
   end
   initial begin
      repeat (3000) @(posedge ref_clk_i);
      failures++;
      print_verdict;
   end
endmodule // queued_write_bus_release_service_tb_top
